// ---- verilog/sfc_pkg.sv ----
// Shared constants, types and decode helpers of the sample FIFO control block
package sfc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_STATUS    = 8'h00;
  localparam logic [7:0] IDX_COUNT_HI  = 8'h06;
  localparam logic [7:0] IDX_COUNT_LO  = 8'h07;
  localparam logic [7:0] IDX_READ_PORT = 8'h08;
  localparam logic [7:0] IDX_THRESHOLD = 8'h09;
  localparam logic [7:0] IDX_QUEUE_CTL = 8'h0a;

  // Status field positions
  localparam int STAT_DATA_RDY  = 0;
  localparam int STAT_FRAME_RDY = 1;
  localparam int STAT_A_FULL    = 2;

  // Queue control field positions
  localparam int CTL_OVERWRITE = 1;
  localparam int CTL_AF_TYPE   = 2;
  localparam int CTL_RCF       = 3;
  localparam int CTL_FLUSH     = 4;

  // Reset values
  localparam logic [7:0] THRESHOLD_RST = 8'h7f;
  localparam logic       RCF_RST       = 1'b1;
  localparam logic       AF_TYPE_RST   = 1'b0;
  localparam logic       OVERWRITE_RST = 1'b0;

  // Sizes, limits and bus response codes
  localparam int         DEPTH        = 256;
  localparam logic [6:0] LOST_MAX     = 7'h7f;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  // Queue control settings held by software
  typedef struct packed {
    logic rcf;
    logic af_type;
    logic overwrite;
  } sfc_ctl_t;

  // Sample entering the queue
  typedef struct packed {
    logic [7:0] data;
  } sfc_samp_t;

  // Byte address to register index; low two and upper two address bits must be zero
  function automatic logic [8:0] sfc_idx(input logic [11:0] addr);
    sfc_idx = (addr[1:0] == 2'h0 && addr[11:10] == 2'h0) ?
              {1'b1, addr[9:2]} : 9'h000;
  endfunction : sfc_idx

endpackage : sfc_pkg

// ---- verilog/sfc_buf2.sv ----
// Two-entry valid/ready buffer in front of the sample queue
`timescale 1ns/100ps
module sfc_buf2 #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         nrst_i,
  // Filling side
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  // Draining side
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);

  logic [W-1:0] slot_q [2];
  logic         rd_q;
  logic         wr_q;
  logic [1:0]   used_q;
  logic         push;
  logic         pop;

  // Handshakes
  assign in_ready_o  = (used_q != 2'd2);
  assign out_valid_o = (used_q != 2'd0);
  assign out_data_o  = slot_q[rd_q];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Storage slots, written in turn
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      slot_q[0] <= '0;
      slot_q[1] <= '0;
      wr_q      <= 1'b0;
    end else if (push) begin
      slot_q[wr_q] <= in_data_i;
      wr_q         <= ~wr_q;
    end
  end

  // Read side and occupancy
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_q   <= 1'b0;
      used_q <= 2'd0;
    end else begin
      if (pop) rd_q <= ~rd_q;
      if (push && !pop) used_q <= used_q + 2'd1;
      else if (pop && !push) used_q <= used_q - 2'd1;
    end
  end

endmodule : sfc_buf2

// ---- verilog/sfc_store.sv ----
// Flip-flop sample storage addressed by read and write index
`timescale 1ns/100ps
module sfc_store #(
  parameter int W  = 8,
  parameter int AW = 8
) (
  // Clock and reset
  input  wire logic          clk_sys_i,
  input  wire logic          nrst_i,
  // Write port
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [W-1:0]  wdata_i,
  // Read port
  input  wire logic [AW-1:0] raddr_i,
  output logic [W-1:0]       rdata_o
);

  logic [W-1:0] mem_q [2**AW];

  // One cell per entry; the write enable is decoded per cell
  for (genvar i = 0; i < 2**AW; i++) begin : g_cell
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) mem_q[i] <= '0;
      else if (we_i && waddr_i == AW'(i)) mem_q[i] <= wdata_i;
    end
  end

  assign rdata_o = mem_q[raddr_i];

endmodule : sfc_store

// ---- verilog/sfc_fifo_ctl.sv ----
// Sample FIFO control and status with an AXI4-Lite register slave
//
// Contract
// - 9-bit fill count: up on push, down on read
// - Low count byte readable, read-only
// - Full queue loses new or old sample
// - 7-bit lost counter, saturating, read-only
// - Read port pops next stored byte
// - Threshold is free space for almost-full
// - Flush bit clears indices, count, self-clears
// - Read-clears-flags 0: only status read clears
// - Read-clears-flags 1: data or status read clears
// - Repeat mode: almost-full reasserts every sample
// - Once mode: almost-full only on fresh condition
// - Overwrite advances both indices; else drop, hold
`timescale 1ns/100ps
module sfc_fifo_ctl #(
  parameter int DEPTH_LOG2 = 8
) (
  // Clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              nrst_i,
  // Sample stream from the sequencer
  input  wire logic              samp_valid_i,
  input  wire sfc_pkg::sfc_samp_t samp_i,
  output logic                   samp_ready_o,
  // Frame completion event
  input  wire logic              frame_done_i,
  // Flag levels
  output logic                   a_full_o,
  output logic                   frame_rdy_o,
  output logic                   data_rdy_o,
  // AXI4-Lite write address
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [11:0]       s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  // AXI4-Lite write response
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [11:0]       s_axi_araddr,
  // AXI4-Lite read data
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp
);

  localparam int CW = DEPTH_LOG2 + 1;
  localparam logic [CW-1:0] FULL_CNT = CW'(sfc_pkg::DEPTH);

  // Index names one of the mapped registers; shared by both bus directions
  function automatic logic is_mapped(input logic [8:0] dec);
    case (dec)
      {1'b1, sfc_pkg::IDX_STATUS},
      {1'b1, sfc_pkg::IDX_COUNT_HI},
      {1'b1, sfc_pkg::IDX_COUNT_LO},
      {1'b1, sfc_pkg::IDX_READ_PORT},
      {1'b1, sfc_pkg::IDX_THRESHOLD},
      {1'b1, sfc_pkg::IDX_QUEUE_CTL}: is_mapped = 1'b1;
      default:                        is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  // Queue state
  logic [DEPTH_LOG2-1:0] write_index_q;
  logic [DEPTH_LOG2-1:0] read_index_q;
  logic [CW-1:0]         count_q;
  logic [6:0]            lost_sample_count_q;
  logic [7:0]            threshold_q;
  sfc_pkg::sfc_ctl_t     ctl_q;
  logic                  a_full_q;
  logic                  frame_rdy_q;
  logic                  data_rdy_q;
  logic                  af_seen_q;

  // Bus channel state
  logic                  aw_held_q;
  logic [11:0]           aw_addr_q;
  logic                  w_held_q;
  logic [31:0]           w_data_q;
  logic [3:0]            w_strb_q;
  logic                  bvalid_q;
  logic [1:0]            bresp_q;
  logic                  rvalid_q;
  logic [31:0]           rdata_q;
  logic [1:0]            rresp_q;

  // Internal strobes
  logic                  bv_valid;
  sfc_pkg::sfc_samp_t    bv_data;
  logic                  bv_ready;
  logic                  take_sample;
  logic                  full;
  logic                  do_write;
  logic                  rd_take;
  logic [8:0]            wr_dec;
  logic [8:0]            rd_dec;
  logic                  flush;
  logic                  pop;
  logic                  stat_read;
  logic                  clear_flags;
  logic                  stores;
  logic                  advance_rd;
  logic [CW-1:0]         count_after;
  logic                  af_now;
  logic [7:0]            store_rdata;

  // Input buffer; a stall here pushes back on the sequencer
  sfc_buf2 #(
    .W ($bits(sfc_pkg::sfc_samp_t))
  ) u_buf (
    .clk_sys_i   (clk_sys_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (samp_valid_i),
    .in_data_i   (samp_i),
    .in_ready_o  (samp_ready_o),
    .out_valid_o (bv_valid),
    .out_data_o  (bv_data),
    .out_ready_i (bv_ready)
  );

  // Sample storage
  sfc_store #(
    .W  (8),
    .AW (DEPTH_LOG2)
  ) u_store (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .we_i      (stores),
    .waddr_i   (write_index_q),
    .wdata_i   (bv_data.data),
    .raddr_i   (read_index_q),
    .rdata_o   (store_rdata)
  );

  // Register write: both halves held, response slot free
  assign do_write = aw_held_q && w_held_q && !bvalid_q;
  assign wr_dec   = sfc_pkg::sfc_idx(aw_addr_q);
  assign flush    = do_write && wr_dec == {1'b1, sfc_pkg::IDX_QUEUE_CTL}
                    && w_strb_q[0] && w_data_q[sfc_pkg::CTL_FLUSH];

  // Register read accepted this cycle
  assign rd_take   = s_axi_arvalid && s_axi_arready;
  assign rd_dec    = sfc_pkg::sfc_idx(s_axi_araddr);
  assign pop       = rd_take && rd_dec == {1'b1, sfc_pkg::IDX_READ_PORT}
                     && count_q != '0;
  assign stat_read = rd_take && rd_dec == {1'b1, sfc_pkg::IDX_STATUS};

  // Flag clearing depends on the read-clears-flags setting
  assign clear_flags = stat_read
                       || (ctl_q.rcf && rd_take
                           && rd_dec == {1'b1, sfc_pkg::IDX_READ_PORT});

  // Drain stalls on pop or flush so the count never sees two moves at once
  assign bv_ready    = !pop && !flush;
  assign take_sample = bv_valid && bv_ready;
  assign full        = (count_q == FULL_CNT);
  assign stores      = take_sample && (!full || ctl_q.overwrite);
  assign advance_rd  = take_sample && full && ctl_q.overwrite;

  // Count after this cycle's push or pop, for the threshold check
  // A pop is judged at its new level, so once mode sees a drain below threshold
  always_comb begin
    count_after = count_q;
    if (pop) count_after = count_q - CW'(1);
    else if (take_sample && !full) count_after = count_q + CW'(1);
  end

  // Almost full when free space is at or below the threshold
  assign af_now = (10'(count_after) + 10'(threshold_q)) >= 10'(sfc_pkg::DEPTH);

  // Write index
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) write_index_q <= '0;
    else if (flush) write_index_q <= '0;
    else if (stores) write_index_q <= write_index_q + DEPTH_LOG2'(1);
  end

  // Read index
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) read_index_q <= '0;
    else if (flush) read_index_q <= '0;
    else if (pop || advance_rd) read_index_q <= read_index_q + DEPTH_LOG2'(1);
  end

  // Fill count; an overwrite keeps it at full
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) count_q <= '0;
    else if (flush) count_q <= '0;
    else if (pop) count_q <= count_q - CW'(1);
    else if (take_sample && !full) count_q <= count_q + CW'(1);
  end

  // Lost samples saturate rather than wrap; flush leaves the tally alone
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) lost_sample_count_q <= '0;
    else if (take_sample && full && lost_sample_count_q != sfc_pkg::LOST_MAX)
      lost_sample_count_q <= lost_sample_count_q + 7'h01;
  end

  // Threshold and queue control settings
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      threshold_q     <= sfc_pkg::THRESHOLD_RST;
      ctl_q.rcf       <= sfc_pkg::RCF_RST;
      ctl_q.af_type   <= sfc_pkg::AF_TYPE_RST;
      ctl_q.overwrite <= sfc_pkg::OVERWRITE_RST;
    end else if (do_write && w_strb_q[0]) begin
      if (wr_dec == {1'b1, sfc_pkg::IDX_THRESHOLD}) threshold_q <= w_data_q[7:0];
      if (wr_dec == {1'b1, sfc_pkg::IDX_QUEUE_CTL}) begin
        ctl_q.rcf       <= w_data_q[sfc_pkg::CTL_RCF];
        ctl_q.af_type   <= w_data_q[sfc_pkg::CTL_AF_TYPE];
        ctl_q.overwrite <= w_data_q[sfc_pkg::CTL_OVERWRITE];
      end
    end
  end

  // Condition seen at the last push or pop, so once mode can spot a fresh one
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) af_seen_q <= 1'b0;
    else if (flush) af_seen_q <= 1'b0;
    else if (take_sample || pop) af_seen_q <= af_now;
  end

  // Almost-full flag; a set in the clearing cycle wins
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) a_full_q <= 1'b0;
    else if (take_sample && af_now && (!ctl_q.af_type || !af_seen_q))
      a_full_q <= 1'b1;
    else if (clear_flags) a_full_q <= 1'b0;
  end

  // Frame-ready flag
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) frame_rdy_q <= 1'b0;
    else if (frame_done_i) frame_rdy_q <= 1'b1;
    else if (clear_flags) frame_rdy_q <= 1'b0;
  end

  // Data-ready flag, set by every stored sample
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) data_rdy_q <= 1'b0;
    else if (stores) data_rdy_q <= 1'b1;
    else if (clear_flags) data_rdy_q <= 1'b0;
  end

  assign a_full_o    = a_full_q;
  assign frame_rdy_o = frame_rdy_q;
  assign data_rdy_o  = data_rdy_q;

  // Write address channel: held until the write is done
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  // Write data channel, taken independently of the address
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      w_held_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready  = !w_held_q;

  // Write response; read-only writes ignored with OKAY, unmapped refused
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bvalid_q <= 1'b0;
      bresp_q  <= sfc_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= is_mapped(wr_dec) ? sfc_pkg::RESP_OKAY : sfc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // Read channel: one read at a time, data registered at acceptance
  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= sfc_pkg::RESP_OKAY;
    end else if (rd_take) begin
      rvalid_q <= 1'b1;
      rresp_q  <= is_mapped(rd_dec) ? sfc_pkg::RESP_OKAY : sfc_pkg::RESP_SLVERR;
      rdata_q  <= '0;
      case (rd_dec)
        {1'b1, sfc_pkg::IDX_STATUS}:
          rdata_q[2:0] <= {a_full_q, frame_rdy_q, data_rdy_q};
        {1'b1, sfc_pkg::IDX_COUNT_HI}:
          rdata_q[7:0] <= {count_q[CW-1], lost_sample_count_q};
        {1'b1, sfc_pkg::IDX_COUNT_LO}:
          rdata_q[7:0] <= count_q[7:0];
        {1'b1, sfc_pkg::IDX_READ_PORT}:
          rdata_q[7:0] <= (count_q != '0) ? store_rdata : 8'h00;
        {1'b1, sfc_pkg::IDX_THRESHOLD}:
          rdata_q[7:0] <= threshold_q;
        {1'b1, sfc_pkg::IDX_QUEUE_CTL}:
          rdata_q[4:1] <= {1'b0, ctl_q.rcf, ctl_q.af_type, ctl_q.overwrite};
        default:
          rdata_q <= '0;                                                      // Unmapped reads zero
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

endmodule : sfc_fifo_ctl

// ---- sim/sfc_fifo_ctl_asserts.sv ----
// Port-level checks of the sample FIFO control block
`timescale 1ns/100ps
module sfc_fifo_ctl_asserts (
  // Clock, reset and frame event
  input wire logic        clk_sys_i,
  input wire logic        nrst_i,
  input wire logic        frame_done_i,
  // Flags
  input wire logic        a_full_o,
  input wire logic        frame_rdy_o,
  input wire logic        data_rdy_o,
  // AXI4-Lite
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  // Read acceptance, the only legal cause of a flag clear
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  property p_af_clr; $fell(a_full_o) |-> $past(ar_hs); endproperty
  a_af_clr: assert property (p_af_clr) else $error("almost-full fell without a read");
  property p_fr_clr; $fell(frame_rdy_o) |-> $past(ar_hs); endproperty
  a_fr_clr: assert property (p_fr_clr) else $error("frame flag fell without a read");
  property p_dr_clr; $fell(data_rdy_o) |-> $past(ar_hs); endproperty
  a_dr_clr: assert property (p_dr_clr) else $error("data flag fell without a read");
  property p_fr_set; frame_done_i |=> frame_rdy_o; endproperty
  a_fr_set: assert property (p_fr_set) else $error("frame flag not set");
  // Answer stays put until taken
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped early");
  property p_r_lat; ar_hs |=> s_axi_rvalid; endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_dp_rd;
    ar_hs && s_axi_araddr == 12'h020 |=>
      s_axi_rresp == sfc_pkg::RESP_OKAY && s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_dp_rd: assert property (p_dp_rd) else $error("read port answer malformed");
  property p_lo_rd;
    ar_hs && s_axi_araddr == 12'h01c |=>
      s_axi_rresp == sfc_pkg::RESP_OKAY && s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_lo_rd: assert property (p_lo_rd) else $error("count read malformed");
  property p_unm;
    ar_hs && s_axi_araddr[11:10] != 2'h0 |=>
      s_axi_rresp == sfc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not refused");
  property p_b_lat; s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid; endproperty
  a_b_lat: assert property (p_b_lat) else $error("write answer late");
  // Main scenarios reached
  c_af: cover property (a_full_o);
  c_fr: cover property ($rose(frame_rdy_o));
  c_dp: cover property (ar_hs && s_axi_araddr == 12'h020 && data_rdy_o);
endmodule : sfc_fifo_ctl_asserts

bind sfc_fifo_ctl sfc_fifo_ctl_asserts i_chk (.*);

// ---- sim/sfc_host.sv ----
// Host model issuing AXI4-Lite register reads and writes
`timescale 1ns/100ps
module sfc_host (
  input  wire logic        clk_sys_i,
  output logic             s_axi_awvalid,
  output logic [11:0]      s_axi_awaddr,
  output logic             s_axi_wvalid,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_bready,
  output logic             s_axi_arvalid,
  output logic [11:0]      s_axi_araddr,
  output logic             s_axi_rready,
  input  wire logic        s_axi_awready,
  input  wire logic        s_axi_wready,
  input  wire logic        s_axi_bvalid,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_arready,
  input  wire logic        s_axi_rvalid,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp
);
  // Idle bus; handshakes judged at the falling edge to avoid edge races
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} = 60'h0;
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ha, hw, pa, pw, hb;
    ha = 1'b0;
    hw = 1'b0;
    @(posedge clk_sys_i);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    while (!(ha && hw)) begin
      @(negedge clk_sys_i);
      pa = !ha && s_axi_awready;
      pw = !hw && s_axi_wready;
      @(posedge clk_sys_i);
      if (pa) s_axi_awvalid <= 1'b0;
      if (pw) s_axi_wvalid <= 1'b0;
      ha = ha || pa;
      hw = hw || pw;
    end
    do begin
      @(negedge clk_sys_i);
      hb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk_sys_i);
    end while (!hb);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic h;
    @(posedge clk_sys_i);
    {s_axi_arvalid, s_axi_rready} <= 2'h2;
    s_axi_araddr <= a;
    do begin
      @(negedge clk_sys_i);
      h = s_axi_arready;
      @(posedge clk_sys_i);
    end while (!h);
    s_axi_arvalid <= 1'b0;
    // Answer left waiting one cycle so the hold check sees a stall
    @(posedge clk_sys_i);
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clk_sys_i);
      h = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk_sys_i);
    end while (!h);
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : sfc_host

// ---- sim/tb_top.sv ----
// Directed bench for the sample FIFO control block
`timescale 1ns/100ps
module tb_top;
  localparam logic [11:0] ST = 12'h000, HI = 12'h018, LO = 12'h01c;
  localparam logic [11:0] DP = 12'h020, TH = 12'h024, QC = 12'h028;
  localparam logic [1:0] OK = sfc_pkg::RESP_OKAY, ERR = sfc_pkg::RESP_SLVERR;
  logic clk_sys_i, nrst_i, samp_valid_i, samp_ready_o, frame_done_i;
  logic a_full_o, frame_rdy_o, data_rdy_o;
  sfc_pkg::sfc_samp_t samp_i;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int errors = 0, comparisons = 0, cyc = 0;
  sfc_fifo_ctl i_dut (.*);
  sfc_host i_host (.*);
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  task automatic report_and_stop;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  // Hang guard, well above the thousand or so cycles the run needs
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rc(input logic [11:0] a, input logic [33:0] e);
    logic [31:0] d;
    logic [1:0] r;
    i_host.rd(a, d, r);
    chk({r, d}, e);
  endtask : rc
  task automatic wc(input logic [11:0] a, input logic [7:0] d, input logic [1:0] e);
    logic [1:0] r;
    i_host.wr(a, {24'h0, d}, r);
    chk({32'h0, r}, {32'h0, e});
  endtask : wc
  // Flags as {almost-full, frame, data}, sampled mid-cycle
  task automatic fl(input logic [2:0] e);
    @(negedge clk_sys_i);
    chk({31'h0, a_full_o, frame_rdy_o, data_rdy_o}, {31'h0, e});
  endtask : fl
  // Pushes n samples, then lets the input buffer drain
  task automatic pushn(input int n, input logic [7:0] b);
    logic h;
    for (int k = 0; k < n; k++) begin
      @(posedge clk_sys_i);
      samp_valid_i <= 1'b1;
      samp_i.data <= b + k[7:0];
      do begin
        @(negedge clk_sys_i);
        h = samp_ready_o;
        @(posedge clk_sys_i);
      end while (!h);
      samp_valid_i <= 1'b0;
    end
    repeat (4) @(posedge clk_sys_i);
  endtask : pushn
  initial begin
    {nrst_i, samp_valid_i, frame_done_i} = 3'h0;
    samp_i = '0;
    repeat (3) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    @(negedge clk_sys_i);
    chk({33'h0, samp_ready_o}, 34'h1);
    // Reset values, read-only and unmapped places
    rc(TH, {OK, 32'h7f});
    rc(QC, {OK, 32'h08});
    wc(LO, 8'h55, OK);
    rc(LO, {OK, 32'h0});
    wc(12'h400, 8'h01, ERR);
    rc(12'h400, {ERR, 32'h0});
    wc(12'h004, 8'h01, ERR);
    rc(12'h004, {ERR, 32'h0});
    // In-order read back; data read clears flags by default
    pushn(3, 8'h10);
    @(posedge clk_sys_i);
    frame_done_i <= 1'b1;
    @(posedge clk_sys_i);
    frame_done_i <= 1'b0;
    fl(3'b011);
    rc(LO, {OK, 32'h3});
    rc(DP, {OK, 32'h10});
    fl(3'b000);
    rc(DP, {OK, 32'h11});
    rc(DP, {OK, 32'h12});
    rc(LO, {OK, 32'h0});
    // Data read leaves flags when the clear option is off
    wc(QC, 8'h00, OK);
    pushn(2, 8'h20);
    rc(DP, {OK, 32'h20});
    fl(3'b001);
    rc(ST, {OK, 32'h1});
    fl(3'b000);
    // Flush empties the queue and reads back clear
    wc(QC, 8'h10, OK);
    rc(QC, {OK, 32'h0});
    rc(LO, {OK, 32'h0});
    rc(DP, {OK, 32'h0});
    // Repeat mode, three stored samples leave 253 free
    wc(TH, 8'hfd, OK);
    rc(TH, {OK, 32'hfd});
    pushn(2, 8'h30);
    fl(3'b001);
    pushn(1, 8'h32);
    fl(3'b101);
    rc(ST, {OK, 32'h5});
    pushn(1, 8'h33);
    fl(3'b101);
    rc(ST, {OK, 32'h5});
    // Once mode after flush
    wc(QC, 8'h14, OK);
    pushn(3, 8'h40);
    fl(3'b101);
    rc(ST, {OK, 32'h5});
    pushn(1, 8'h43);
    fl(3'b001);
    // Drain below the threshold, so the next rise is fresh
    rc(DP, {OK, 32'h40});
    rc(DP, {OK, 32'h41});
    pushn(1, 8'h44);
    fl(3'b101);
    rc(ST, {OK, 32'h5});
    // Full queue: drop new samples, saturate lost count
    wc(TH, 8'h00, OK);
    wc(QC, 8'h10, OK);
    pushn(255, 8'h00);
    fl(3'b001);
    pushn(1, 8'hff);
    fl(3'b101);
    rc(HI, {OK, 32'h80});
    rc(LO, {OK, 32'h0});
    pushn(3, 8'hee);
    rc(HI, {OK, 32'h83});
    pushn(127, 8'hee);
    rc(HI, {OK, 32'hff});
    rc(DP, {OK, 32'h0});
    // Overwrite mode loses the oldest sample
    wc(QC, 8'h02, OK);
    pushn(2, 8'ha0);
    rc(DP, {OK, 32'h2});
    rc(LO, {OK, 32'hff});
    rc(HI, {OK, 32'h7f});
    report_and_stop();
  end
endmodule : tb_top
